// >>> core/supervisory_watchdog_timer.sv
/*
  supervisory watchdog timer: kick window, long window, fault pulse.
  assumes the timing strap and undervoltage event are synchronous to CLK.
*/
`timescale 1ns/1ps
module supervisory_watchdog_timer
  import wdt_pkg::*;
#(
  parameter int TICK_CYCLES = BASE_TICK_CYC,
  parameter int WINDOW_T = WINDOW_TICKS,
  parameter int LONG_T = LONG_WINDOW_TICKS,
  parameter int PULSE_T = PULSE_TICKS
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic WATCHDOG_KICK_IN,
  input wire logic TIMING_CAP_PIN,
  input wire logic UNDERVOLTAGE_LOCKOUT_EVENT,
  output logic WATCHDOG_FAULT_OUT_O,
  output logic WATCHDOG_FAULT_OUT_OE,
  output logic FAULT_ACTIVE
);
  // ===========================================================
  // kick synchroniser and edge detect
  logic sync1, sync2, sync3;
  logic next_sync1, next_sync2, next_sync3;
  logic kick_edge;
  always_comb begin
    next_sync1 = WATCHDOG_KICK_IN; // RULE8
    next_sync2 = sync1;
    next_sync3 = sync2;
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      sync3 <= next_sync3;
    end
  end
  // sync1 feeds only sync2; the edge is taken from the later stages
  assign kick_edge = sync2 ^ sync3; // RULE8 RULE2

  // ===========================================================
  // base tick divider
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic tick;
  assign tick = (div_cnt == DIV_W'(TICK_CYCLES - 1));
  always_comb begin
    if (tick) begin
      next_div_cnt = '0; // RULE6
    end else begin
      next_div_cnt = div_cnt + DIV_W'(1);
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ===========================================================
  // watchdog state machine
  wdt_state_t state, next_state;
  logic [TICK_W-1:0] tcnt, next_tcnt;
  logic disabled;
  assign disabled = TIMING_CAP_PIN; // RULE7
  always_comb begin
    next_state = state;
    next_tcnt = tcnt;
    if (disabled) begin
      next_state = ST_OFF; // RULE7
      next_tcnt = '0;
    end else if (UNDERVOLTAGE_LOCKOUT_EVENT) begin
      next_state = ST_PULSE; // RULE4
      next_tcnt = '0;
    end else begin
      case (state)
        ST_OFF: begin
          next_state = ST_WINDOW;
          next_tcnt = '0;
        end
        ST_WINDOW, ST_LONG: begin
          if (kick_edge) begin
            next_state = ST_WINDOW; // RULE2
            next_tcnt = '0;
          end else if (tick) begin
            if (tcnt == TICK_W'(((state == ST_LONG) ? LONG_T : WINDOW_T) - 1)) begin
              next_state = ST_PULSE; // RULE2 RULE3
              next_tcnt = '0;
            end else begin
              next_tcnt = tcnt + TICK_W'(1);
            end
          end
        end
        ST_PULSE: begin
          // kicks during the pulse are ignored; the long window follows
          if (tick) begin
            if (tcnt == TICK_W'(PULSE_T - 1)) begin
              next_state = ST_LONG; // RULE3
              next_tcnt = '0;
            end else begin
              next_tcnt = tcnt + TICK_W'(1);
            end
          end
        end
        default: begin
          next_state = ST_WINDOW;
          next_tcnt = '0;
        end
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state <= ST_WINDOW;
      tcnt <= '0;
    end else begin
      state <= next_state;
      tcnt <= next_tcnt;
    end
  end

  // ===========================================================
  // open-drain fault pin, registered
  od_pin_t pin, next_pin;
  always_comb begin
    next_pin.fault_o = 1'b0; // RULE5
    next_pin.fault_oe = (next_state == ST_PULSE); // RULE5
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pin <= '0;
    end else begin
      pin <= next_pin;
    end
  end
  assign WATCHDOG_FAULT_OUT_O = pin.fault_o;
  assign WATCHDOG_FAULT_OUT_OE = pin.fault_oe;
  assign FAULT_ACTIVE = pin.fault_oe;

  // ===========================================================
  // pulse length watch, read by the checks only
  // restarts on entry and on every undervoltage cycle, since either one
  // begins a fresh full pulse
  logic [31:0] pulse_len, next_pulse_len;
  always_comb begin
    if (next_state != ST_PULSE) begin
      next_pulse_len = 32'h00000000;
    end else if (state != ST_PULSE || UNDERVOLTAGE_LOCKOUT_EVENT) begin
      next_pulse_len = 32'h00000001;
    end else begin
      next_pulse_len = pulse_len + 32'h00000001;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pulse_len <= 32'h00000000;
    end else begin
      pulse_len <= next_pulse_len;
    end
  end

  // ===========================================================
  // checks
  // most checks leave out strap and undervoltage cycles, which override everything
  never_high_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE5
    WATCHDOG_FAULT_OUT_O == 1'b0) else $error("fault pin driven high");
  reset_idle_a: assert property (@(posedge CLK) // RULE5
    !RESETN |=> (state == ST_WINDOW && tcnt == '0 && !WATCHDOG_FAULT_OUT_OE))
    else $error("not idle after reset");
  disable_quiet_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE7
    disabled |=> !WATCHDOG_FAULT_OUT_OE) else $error("fault while disabled");
  off_release_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE7
    (state == ST_OFF && !disabled && !UNDERVOLTAGE_LOCKOUT_EVENT)
    |=> (state == ST_WINDOW && tcnt == '0))
    else $error("window did not restart after strap");
  undervoltage_lockout_event_pulse_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE4
    (UNDERVOLTAGE_LOCKOUT_EVENT && !disabled) |=> WATCHDOG_FAULT_OUT_OE)
    else $error("no pulse after undervoltage");
  kick_restart_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE2
    (kick_edge && !disabled && !UNDERVOLTAGE_LOCKOUT_EVENT
     && (state == ST_WINDOW || state == ST_LONG)) |=> (state == ST_WINDOW && tcnt == '0))
    else $error("kick did not restart window");
  window_wait_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE2
    (state == ST_WINDOW && !(tick && tcnt == TICK_W'(WINDOW_T - 1))
     && !disabled && !UNDERVOLTAGE_LOCKOUT_EVENT) |=> !WATCHDOG_FAULT_OUT_OE)
    else $error("pulse before window expiry");
  window_expire_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE2
    (state == ST_WINDOW && tick && !kick_edge && tcnt == TICK_W'(WINDOW_T - 1)
     && !disabled && !UNDERVOLTAGE_LOCKOUT_EVENT) |=> WATCHDOG_FAULT_OUT_OE)
    else $error("window expiry gave no pulse");
  pulse_hold_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE2
    (state == ST_PULSE && !tick && !disabled) |=> (state == ST_PULSE))
    else $error("pulse cut short");
  pulse_count_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE6
    (state == ST_PULSE && tick && tcnt != TICK_W'(PULSE_T - 1) && !disabled
     && !UNDERVOLTAGE_LOCKOUT_EVENT)
    |=> (state == ST_PULSE && tcnt == $past(tcnt) + TICK_W'(1)))
    else $error("pulse tick not counted");
  pulse_max_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE2
    (state == ST_PULSE) |-> (pulse_len <= 32'(PULSE_T * TICK_CYCLES)))
    else $error("fault pulse too long");
  pulse_min_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE4
    (state == ST_PULSE && next_state == ST_LONG)
    |-> (pulse_len > 32'((PULSE_T - 1) * TICK_CYCLES)))
    else $error("fault pulse too short");
  pulse_to_long_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE3
    (state == ST_PULSE && tick && tcnt == TICK_W'(PULSE_T - 1) && !disabled
     && !UNDERVOLTAGE_LOCKOUT_EVENT) |=> state == ST_LONG)
    else $error("pulse did not end into long window");
  long_wait_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE3
    (state == ST_LONG && !kick_edge && !(tick && tcnt == TICK_W'(LONG_T - 1))
     && !disabled && !UNDERVOLTAGE_LOCKOUT_EVENT) |=> (state == ST_LONG))
    else $error("long window left early");
  long_expire_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE3
    (state == ST_LONG && tick && !kick_edge && tcnt == TICK_W'(LONG_T - 1)
     && !disabled && !UNDERVOLTAGE_LOCKOUT_EVENT) |=> WATCHDOG_FAULT_OUT_OE)
    else $error("long window expiry gave no pulse");
  sync_chain_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE8
    (sync2 == $past(sync1)) && (sync3 == $past(sync2)))
    else $error("kick chain skipped a stage");
  edge_detect_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE8
    kick_edge |-> ($past(sync1, 2) != $past(sync1, 1)))
    else $error("edge without sample change");
  tick_period_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE6
    tick |=> !tick) else $error("tick wider than one cycle");
  pin_follows_state_a: assert property (@(posedge CLK) disable iff (!RESETN) // RULE5
    WATCHDOG_FAULT_OUT_OE == (state == ST_PULSE))
    else $error("pin and state disagree");
endmodule

// >>> dv/host_kicker.sv
/*
  host model that toggles the watchdog kick at a set spacing.
  assumes the bench keeps GAP well inside the short window.
*/
`timescale 1ns/1ps
module host_kicker (
  input wire logic CLK,
  input wire logic RUN,
  input wire logic [5:0] GAP,
  output logic KICK
);
  // ==========================================
  // kick generator
  logic [5:0] cnt = 6'h00;
  initial KICK = 1'b0;
  // stops dead when run drops, so the device must time out on its own
  always @(posedge CLK) begin
    if (!RUN || cnt >= GAP) cnt <= 6'h00;
    else cnt <= cnt + 6'h01;
    if (RUN && cnt >= GAP) KICK <= ~KICK;
  end
endmodule

// >>> dv/supervisory_watchdog_timer_bench.sv
/*
  self-checking bench for the watchdog: pulse lengths, gaps, disable.
  assumes short sim parameters: 4-cycle tick, 10/40/5 tick intervals.
*/
`timescale 1ns/1ps
module supervisory_watchdog_timer_bench;
  import wdt_pkg::*;
  localparam int TK = 4;
  logic CLK = 0, prev_oe = 0;
  logic RESETN, TCAP, UV, run;
  logic kick, oe, o, act;
  logic [5:0] gap;
  int err_count = 0, num_checks = 0, len = 0, idle = 0;
  int q[$];
  always #25 CLK = ~CLK;
  host_kicker host_u (.CLK(CLK), .RUN(run), .GAP(gap), .KICK(kick));
  supervisory_watchdog_timer #(.TICK_CYCLES(TK), .WINDOW_T(10), .LONG_T(40), .PULSE_T(5))
    dut_u (.CLK(CLK), .RESETN(RESETN), .WATCHDOG_KICK_IN(kick), .TIMING_CAP_PIN(TCAP),
    .UNDERVOLTAGE_LOCKOUT_EVENT(UV), .WATCHDOG_FAULT_OUT_O(o),
    .WATCHDOG_FAULT_OUT_OE(oe), .FAULT_ACTIVE(act));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // watcher: each pulse consumes the oldest note
  // gap is rounded since the first tick may jitter by one
  // sampled mid-cycle, away from the edge that launches the pin
  always @(negedge CLK) begin
    if (oe === 1'b1) len++;
    else idle++;
    if (oe === 1'b1 && prev_oe !== 1'b1) begin
      check("active copy on", act, 1);
      check("drain while low", o, 0);
      if (q.size() == 0) check("unexpected pulse", 1, 0);
      else if (q[0] != 0) check("gap ticks", (idle + TK / 2) / TK, q[0]);
      len = 1;
    end
    if (oe !== 1'b1 && prev_oe === 1'b1) begin
      check("pulse ticks", (len + TK - 1) / TK, 5);
      check("drain level", o, 0);
      check("active copy", act, 0);
      if (q.size() > 0) void'(q.pop_front());
      idle = 1;
    end
    prev_oe = oe;
  end
  // ==========================================
  // stimulus
  initial begin
    RESETN <= 1'b0;
    TCAP <= 1'b0;
    UV <= 1'b0;
    run <= 1'b0;
    gap <= 6'h14;
    void'($urandom(43718));
    repeat (5) @(posedge CLK);
    RESETN <= 1;
    run <= 1;
    repeat (8) begin
      @(posedge CLK);
      gap <= 6'($urandom_range(8, 30));
      repeat (60) @(posedge CLK);
    end
    q.push_back(0);
    q.push_back(40);
    run <= 0;
    repeat (300) @(posedge CLK);
    run <= 1;
    repeat (100) @(posedge CLK);
    q.push_back(0);
    UV <= 1;
    @(posedge CLK);
    UV <= 0;
    repeat (100) @(posedge CLK);
    TCAP <= 1;
    run <= 0;
    repeat (300) @(posedge CLK);
    check("released while off", oe, 0);
    TCAP <= 0;
    run <= 1;
    repeat (100) @(posedge CLK);
    check("notes left", q.size(), 0);
    print_verdict();
  end
  initial begin
    #(50 * 5000);
    err_count++;
    print_verdict();
  end
endmodule

// >>> shared/wdt_pkg.sv
/*
  constants and types for the supervisory watchdog timer.
  assumes a single 20 MHz clock and a synchronous active-low reset.
*/
// What this block does
// [RULE1] host toggles kick within 1.62 s
// [RULE2] either edge restarts; timeout gives 202 ms pulse
// [RULE3] after a pulse, next timeout needs 12.9 s
// [RULE4] undervoltage event restarts timer, forces pulse
// [RULE5] fault output open drain, only pulls low
// [RULE6] all intervals from one programmable base tick
// [RULE7] timing pin strapped high disables watchdog
// [RULE8] kick synchronised by two flops before edge detect
package wdt_pkg;
  // ===========================================================
  // timing
  localparam int CLK_HZ = 20000000;
  // nominal base tick is 100 us with the 10 nF timing capacitor
  localparam int BASE_TICK_US = 100;
  localparam int BASE_TICK_CYC = (CLK_HZ / 1000000) * BASE_TICK_US;
  localparam int WINDOW_MS = 1620;
  localparam int LONG_WINDOW_MS = 12900;
  localparam int PULSE_MS = 202;
  localparam int WINDOW_TICKS = WINDOW_MS * 1000 / BASE_TICK_US;
  localparam int LONG_WINDOW_TICKS = LONG_WINDOW_MS * 1000 / BASE_TICK_US;
  localparam int PULSE_TICKS = PULSE_MS * 1000 / BASE_TICK_US;
  localparam int TICK_W = 18;
  localparam int DIV_W = 24;

  // ===========================================================
  // states
  typedef enum logic [1:0] {
    ST_WINDOW = 2'b00,
    ST_PULSE = 2'b01,
    ST_LONG = 2'b11,
    ST_OFF = 2'b10
  } wdt_state_t;

  typedef struct packed {
    logic fault_o;
    logic fault_oe;
  } od_pin_t;
endpackage
